// *** rtl/shssp_pkg.sv ***
package shssp_pkg;

  // Storage and register-space geometry
  localparam int          FIFO_DEPTH     = 512;
  localparam int          SENS_BYTES     = 22;
  localparam int          BYTE_W         = 8;

  // Two-wire slave address: fixed upper six bits, LSB from the address-select pin
  localparam logic [5:0]  I2C_ADDR_HI    = 6'h34;

  // Register map of the serial port (7-bit register addresses)
  localparam logic [6:0]  REG_SENS_BASE  = 7'h00;
  localparam logic [6:0]  REG_FIFO_CNT_H = 7'h20;
  localparam logic [6:0]  REG_FIFO_CNT_L = 7'h21;
  localparam logic [6:0]  REG_FIFO_DATA  = 7'h22;
  localparam logic [6:0]  REG_CFG        = 7'h23;
  localparam logic [6:0]  REG_ADDR_STEP  = 7'h01;

  // Configuration register layout and read values
  localparam int          CFG_I2C_DIS_BIT = 4;
  localparam logic [7:0]  CFG_RST         = 8'h00;
  localparam logic [7:0]  RD_EMPTY_VAL    = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED     = 8'h00;
  localparam int          CNT_HI_SHIFT    = 8;

  // Bit counting and clock stretch length in link-clock cycles
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0]  SPI_LAST_BIT    = 4'h7;
  localparam logic [3:0]  BIT_STEP        = 4'h1;
  localparam logic [1:0]  STRETCH_CYC     = 2'h1;
  localparam logic [1:0]  STRETCH_STEP    = 2'h1;

  // Highest link rates the port is built for
  localparam int          I2C_MAX_KHZ     = 400;
  localparam int          SPI_MAX_KHZ     = 1000;

  typedef enum logic [2:0] {
    I2C_IDLE   = 3'b000,
    I2C_ADDR   = 3'b001,
    I2C_ACK    = 3'b010,
    I2C_RX     = 3'b011,
    I2C_LOAD   = 3'b100,
    I2C_TX     = 3'b101,
    I2C_TXACK  = 3'b110,
    I2C_IGNORE = 3'b111
  } shssp_i2c_e;

endpackage

// *** rtl/shssp_fifo_if.sv ***
interface shssp_fifo_if #(
  parameter int DEPTH = shssp_pkg::FIFO_DEPTH
);
  localparam int CW = $clog2(DEPTH) + 1;

  logic          push;
  logic [7:0]    push_data;
  logic          pop;
  logic [7:0]    head;
  logic [CW-1:0] count;

  modport owner (
    input  push,
    input  push_data,
    input  pop,
    output head,
    output count
  );

  modport user (
    output push,
    output push_data,
    output pop,
    input  head,
    input  count
  );
endinterface

// *** rtl/shssp_fifo.sv ***
module shssp_fifo #(
  parameter int DEPTH = shssp_pkg::FIFO_DEPTH
) (
  input  wire logic       link_clk_in,
  input  wire logic       arst_n_in,
  shssp_fifo_if.owner     fifo
);
  import shssp_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0]         wr_ptr;
    logic [AW-1:0]         rd_ptr;
    logic [CW-1:0]         count;
  } shssp_fifo_s;

  shssp_fifo_s r;
  shssp_fifo_s n;
  logic        do_pop;
  logic        do_push;

  always_comb begin
    n       = r;
    // An empty pop leaves pointers and count alone
    do_pop  = fifo.pop && (r.count != '0);
    // A full FIFO drops the incoming byte unless a pop frees a slot this cycle
    do_push = fifo.push && ((r.count != CW'(DEPTH)) || do_pop);
    if (do_push) begin
      n.mem[r.wr_ptr] = fifo.push_data;
      n.wr_ptr        = r.wr_ptr + AW'(1);
    end
    if (do_pop) begin
      n.rd_ptr = r.rd_ptr + AW'(1);
    end
    // Byte counter follows every push and pop
    if (do_push && !do_pop) begin
      n.count = r.count + CW'(1);
    end else if (do_pop && !do_push) begin
      n.count = r.count - CW'(1);
    end
  end

  always_ff @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign fifo.head  = r.mem[r.rd_ptr];
  assign fifo.count = r.count;
endmodule

// *** rtl/shssp_top.sv ***
// Overview of operation
// - Latest sensor bytes are read-only registers, readable at any time.
// - 512-byte FIFO read through one register; a burst drains consecutive entries.
// - A byte counter tracks valid FIFO bytes on every push and pop.
// - Registers reachable over two-wire up to 400 kHz or four-wire up to 1 MHz.
// - Pins shared: address-select/data-out, clock/clock, data/data-in; select only for four-wire.
// - The port is always a slave; the host supplies clock and addresses.
// - Slave address is six fixed bits plus the address-select pin level.
// - Bus busy from start to stop; a repeated start continues the transaction.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Data moves in 8-bit bytes, any number per transfer.
// - Each byte gets a ninth-clock acknowledge; receiver holds data low while clock high.
// - A slave may hold the clock low; the master waits for release.
// - Acknowledge only a matching address; otherwise leave the bus alone.
// - Write carries register address then data; address auto-increments per byte except at the FIFO data register.
// - Four-wire: first byte read flag and 7-bit address, then data MSB first.
module shssp_top #(
  parameter int SENS_BYTES = shssp_pkg::SENS_BYTES,
  parameter int FIFO_DEPTH = shssp_pkg::FIFO_DEPTH
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  link_clk_in,
  input  wire logic [SENS_BYTES*8-1:0] sensor_data_in,
  input  wire logic                  sensor_valid_in,
  input  wire logic [7:0]            fifo_push_data_in,
  input  wire logic                  fifo_push_valid_in,
  output logic                       fifo_push_ready_out,
  input  wire logic                  scl_in,
  output logic                       scl_out,
  output logic                       scl_oe_out,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_out,
  input  wire logic                  addr_lsb_select_in,
  output logic                       sdo_out,
  output logic                       sdo_oe_out,
  input  wire logic                  spi_chip_select_n_in,
  output logic                       two_wire_port_disable_out
);
  import shssp_pkg::*;

  // Sensor-core side: holds a sample or a FIFO byte until the link side echoes the toggle
  typedef struct packed {
    logic [SENS_BYTES*8-1:0] sens_hold;
    logic                    sreq;
    logic                    sack_s1;
    logic                    sack_s2;
    logic [7:0]              fhold;
    logic                    freq;
    logic                    fack_s1;
    logic                    fack_s2;
  } shssp_sys_s;

  // Link side: pin synchronisers, both serial engines and the register bank
  typedef struct packed {
    logic                    scl_s1;
    logic                    scl_s2;
    logic                    scl_s3;
    logic                    sda_s1;
    logic                    sda_s2;
    logic                    sda_s3;
    logic                    cs_s1;
    logic                    cs_s2;
    logic                    lsb_s1;
    logic                    lsb_s2;
    logic                    sreq_s1;
    logic                    sreq_s2;
    logic                    sreq_s3;
    logic                    freq_s1;
    logic                    freq_s2;
    logic                    freq_s3;
    logic [SENS_BYTES*8-1:0] sens;
    shssp_i2c_e              i2c_st;
    logic [3:0]              cnt;
    logic [7:0]              shift;
    logic                    rw;
    logic                    first;
    logic                    mack;
    logic [1:0]              str;
    logic                    sda_oe;
    logic                    scl_oe;
    logic [3:0]              spi_cnt;
    logic [7:0]              spi_rx;
    logic [7:0]              spi_tx;
    logic                    spi_first;
    logic                    spi_rw;
    logic                    spi_pop;
    logic                    sdo;
    logic                    sdo_oe;
    logic [6:0]              ptr;
    logic [7:0]              cfg;
  } shssp_link_s;

  shssp_sys_s  sr;
  shssp_sys_s  sn;
  shssp_link_s lr;
  shssp_link_s ln;

  shssp_fifo_if #(.DEPTH(FIFO_DEPTH)) fifo_bus ();

  shssp_fifo #(
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .link_clk_in (link_clk_in),
    .arst_n_in   (arst_n_in),
    .fifo        (fifo_bus.owner)
  );

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic pop_c;

  // Register read mux shared by both engines
  function automatic logic [7:0] rd_byte(input logic [6:0] a);
    logic [6:0] idx;
    idx = a - REG_SENS_BASE;
    if ((a >= REG_SENS_BASE) && (int'(idx) < SENS_BYTES)) begin
      rd_byte = lr.sens[int'(idx)*8 +: 8];
    end else begin
      unique case (a)
        REG_FIFO_CNT_H: rd_byte = 8'(fifo_bus.count >> CNT_HI_SHIFT);
        REG_FIFO_CNT_L: rd_byte = fifo_bus.count[7:0];
        REG_FIFO_DATA:  rd_byte = (fifo_bus.count == '0) ? RD_EMPTY_VAL : fifo_bus.head;
        REG_CFG:        rd_byte = lr.cfg;
        default:        rd_byte = RD_UNMAPPED;
      endcase
    end
  endfunction

  // The FIFO register does not advance, so a burst keeps draining it
  function automatic logic [6:0] adv(input logic [6:0] a);
    adv = (a == REG_FIFO_DATA) ? a : a + REG_ADDR_STEP;
  endfunction

  // Sensor registers are read-only; the disable bit is sticky until reset
  function automatic logic [7:0] cfg_wr(input logic [6:0] a, input logic [7:0] d);
    cfg_wr = lr.cfg;
    if (a == REG_CFG) begin
      cfg_wr                  = d;
      cfg_wr[CFG_I2C_DIS_BIT] = d[CFG_I2C_DIS_BIT] | lr.cfg[CFG_I2C_DIS_BIT];
    end
  endfunction

  always_comb begin
    sn         = sr;
    sn.sack_s1 = lr.sreq_s3;
    sn.sack_s2 = sr.sack_s1;
    sn.fack_s1 = lr.freq_s3;
    sn.fack_s2 = sr.fack_s1;
    // A sample arriving while the previous one is still crossing is dropped;
    // the next sample carries fresher data anyway
    if (sensor_valid_in && (sr.sreq == sr.sack_s2)) begin
      sn.sens_hold = sensor_data_in;
      sn.sreq      = ~sr.sreq;
    end
    if (fifo_push_valid_in && fifo_push_ready_out) begin
      sn.fhold = fifo_push_data_in;
      sn.freq  = ~sr.freq;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sr <= '0;
    end else begin
      sr <= sn;
    end
  end

  assign fifo_push_ready_out = (sr.freq == sr.fack_s2);

  assign scl_rise = lr.scl_s2 && !lr.scl_s3;
  assign scl_fall = !lr.scl_s2 && lr.scl_s3;
  // A start is taken only with chip select idle and the two-wire port enabled; a stop is taken at any time
  assign start_c  = lr.scl_s2 && lr.scl_s3 && !lr.sda_s2 && lr.sda_s3 && lr.cs_s2
                    && !lr.cfg[CFG_I2C_DIS_BIT];
  assign stop_c   = lr.scl_s2 && lr.scl_s3 && lr.sda_s2 && !lr.sda_s3;

  assign fifo_bus.push      = lr.freq_s2 != lr.freq_s3;
  assign fifo_bus.push_data = sr.fhold;
  assign fifo_bus.pop       = pop_c;

  always_comb begin
    logic [7:0] b;
    logic [7:0] rx_b;
    b          = '0;
    rx_b       = '0;
    ln         = lr;
    pop_c      = 1'b0;
    ln.scl_s1  = scl_in;
    ln.scl_s2  = lr.scl_s1;
    ln.scl_s3  = lr.scl_s2;
    ln.sda_s1  = sda_in;
    ln.sda_s2  = lr.sda_s1;
    ln.sda_s3  = lr.sda_s2;
    ln.cs_s1   = spi_chip_select_n_in;
    ln.cs_s2   = lr.cs_s1;
    ln.lsb_s1  = addr_lsb_select_in;
    ln.lsb_s2  = lr.lsb_s1;
    ln.sreq_s1 = sr.sreq;
    ln.sreq_s2 = lr.sreq_s1;
    ln.sreq_s3 = lr.sreq_s2;
    ln.freq_s1 = sr.freq;
    ln.freq_s2 = lr.freq_s1;
    ln.freq_s3 = lr.freq_s2;
    if (lr.sreq_s2 != lr.sreq_s3) begin
      ln.sens = sr.sens_hold;
    end

    // A repeated start simply restarts address reception
    if (start_c) begin
      ln.i2c_st = I2C_ADDR;
      ln.cnt    = '0;
      ln.sda_oe = 1'b0;
      ln.scl_oe = 1'b0;
    end else if (stop_c) begin
      ln.i2c_st = I2C_IDLE;
      ln.sda_oe = 1'b0;
      ln.scl_oe = 1'b0;
    end else begin
      unique case (lr.i2c_st)
        I2C_IDLE, I2C_IGNORE: begin
          ln.sda_oe = 1'b0;
        end
        I2C_ADDR: begin
          if (scl_rise) begin
            ln.shift = {lr.shift[6:0], lr.sda_s2};
            ln.cnt   = lr.cnt + BIT_STEP;
          end
          if (scl_fall && (lr.cnt == BITS_PER_BYTE)) begin
            ln.cnt = '0;
            if (lr.shift[7:1] == {I2C_ADDR_HI, lr.lsb_s2}) begin
              ln.rw     = lr.shift[0];
              ln.first  = 1'b1;
              ln.sda_oe = 1'b1;
              ln.i2c_st = I2C_ACK;
            end else begin
              ln.i2c_st = I2C_IGNORE;
            end
          end
        end
        I2C_ACK: begin
          // Acknowledge is held low through the whole ninth clock
          if (scl_fall) begin
            ln.sda_oe = 1'b0;
            if (lr.rw) begin
              ln.i2c_st = I2C_LOAD;
              ln.scl_oe = 1'b1;
              ln.str    = STRETCH_CYC;
            end else begin
              ln.i2c_st = I2C_RX;
            end
          end
        end
        I2C_RX: begin
          if (scl_rise) begin
            ln.shift = {lr.shift[6:0], lr.sda_s2};
            ln.cnt   = lr.cnt + BIT_STEP;
          end
          if (scl_fall && (lr.cnt == BITS_PER_BYTE)) begin
            ln.cnt = '0;
            if (lr.first) begin
              ln.ptr   = lr.shift[6:0];
              ln.first = 1'b0;
            end else begin
              ln.cfg = cfg_wr(lr.ptr, lr.shift);
              ln.ptr = adv(lr.ptr);
            end
            ln.sda_oe = 1'b1;
            ln.i2c_st = I2C_ACK;
          end
        end
        I2C_LOAD: begin
          // Clock held low while the next byte is fetched, so the master waits
          if (lr.str != '0) begin
            ln.str = lr.str - STRETCH_STEP;
          end else begin
            b         = rd_byte(lr.ptr);
            pop_c     = (lr.ptr == REG_FIFO_DATA);
            ln.ptr    = adv(lr.ptr);
            ln.sda_oe = ~b[7];
            ln.shift  = {b[6:0], 1'b0};
            ln.cnt    = BIT_STEP;
            ln.scl_oe = 1'b0;
            ln.i2c_st = I2C_TX;
          end
        end
        I2C_TX: begin
          if (scl_fall) begin
            if (lr.cnt == BITS_PER_BYTE) begin
              ln.sda_oe = 1'b0;
              ln.cnt    = '0;
              ln.i2c_st = I2C_TXACK;
            end else begin
              ln.sda_oe = ~lr.shift[7];
              ln.shift  = {lr.shift[6:0], 1'b0};
              ln.cnt    = lr.cnt + BIT_STEP;
            end
          end
        end
        I2C_TXACK: begin
          if (scl_rise) begin
            ln.mack = ~lr.sda_s2;
          end
          if (scl_fall) begin
            if (lr.mack) begin
              ln.i2c_st = I2C_LOAD;
              ln.scl_oe = 1'b1;
              ln.str    = STRETCH_CYC;
            end else begin
              ln.i2c_st = I2C_IGNORE;
            end
          end
        end
      endcase
    end

    // Four-wire engine: clock idles high, sample on rise, shift out on fall
    if (lr.cs_s2) begin
      ln.spi_cnt   = '0;
      ln.spi_first = 1'b1;
      ln.spi_pop   = 1'b0;
      ln.sdo_oe    = 1'b0;
    end else begin
      ln.sdo_oe = 1'b1;
      if (scl_rise) begin
        rx_b      = {lr.spi_rx[6:0], lr.sda_s2};
        ln.spi_rx = rx_b;
        if (lr.spi_cnt == SPI_LAST_BIT) begin
          ln.spi_cnt = '0;
          if (lr.spi_first) begin
            ln.spi_first = 1'b0;
            ln.spi_rw    = rx_b[7];
            ln.ptr       = rx_b[6:0];
            if (rx_b[7]) begin
              b         = rd_byte(rx_b[6:0]);
              ln.spi_tx = b;
              ln.spi_pop = (rx_b[6:0] == REG_FIFO_DATA) && (fifo_bus.count != '0);
              ln.ptr    = adv(rx_b[6:0]);
            end
          end else if (lr.spi_rw) begin
            b          = rd_byte(lr.ptr);
            ln.spi_tx  = b;
            ln.spi_pop = (lr.ptr == REG_FIFO_DATA) && (fifo_bus.count != '0);
            ln.ptr    = adv(lr.ptr);
          end else begin
            // Only complete data bytes are written; partial bytes die with chip select
            ln.cfg = cfg_wr(lr.ptr, rx_b);
            ln.ptr = adv(lr.ptr);
          end
        end else begin
          ln.spi_cnt = lr.spi_cnt + BIT_STEP;
        end
      end
      if (scl_fall) begin
        // Pop only once the first bit leaves, so a load the host never clocks out loses nothing
        pop_c      = pop_c | lr.spi_pop;
        ln.spi_pop = 1'b0;
        ln.sdo    = lr.spi_tx[7];
        ln.spi_tx = {lr.spi_tx[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lr <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
              sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
              cs_s1: 1'b1, cs_s2: 1'b1, spi_first: 1'b1,
              i2c_st: I2C_IDLE, cfg: CFG_RST, default: '0};
    end else begin
      lr <= ln;
    end
  end

  // Open-drain lines only ever pull low; the port never masters the bus
  assign scl_out                   = 1'b0;
  assign sda_out                   = 1'b0;
  assign scl_oe_out                = lr.scl_oe;
  assign sda_oe_out                = lr.sda_oe;
  assign sdo_out                   = lr.sdo;
  assign sdo_oe_out                = lr.sdo_oe;
  assign two_wire_port_disable_out = lr.cfg[CFG_I2C_DIS_BIT];
endmodule

// *** tb/shssp_chk.sv ***
module shssp_chk #(
  parameter int SENS_BYTES = 22,
  parameter int FIFO_DEPTH = 512
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic link_clk_in,
  input wire logic fifo_push_valid_in,
  input wire logic fifo_push_ready_out,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic sdo_oe_out,
  input wire logic spi_chip_select_n_in,
  input wire logic two_wire_port_disable_out
);
  sequence s_push;
    fifo_push_valid_in && fifo_push_ready_out;
  endsequence
  sequence s_cs_idle;
    spi_chip_select_n_in [*4];
  endsequence
  sequence s_cs_sel;
    !spi_chip_select_n_in [*4];
  endsequence
  property p_scl_open_drain;
    @(posedge link_clk_in) disable iff (!arst_n_in) scl_oe_out |-> scl_out == 1'b0;
  endproperty
  a_scl_open_drain: assert property (p_scl_open_drain) else $error("clock pin driven high");
  property p_sda_open_drain;
    @(posedge link_clk_in) disable iff (!arst_n_in) sda_oe_out |-> sda_out == 1'b0;
  endproperty
  a_sda_open_drain: assert property (p_sda_open_drain) else $error("data pin driven high");
  property p_sdo_quiet;
    @(posedge link_clk_in) disable iff (!arst_n_in) s_cs_idle |-> !sdo_oe_out;
  endproperty
  a_sdo_quiet: assert property (p_sdo_quiet) else $error("data out driven while unselected");
  property p_spi_no_two_wire;
    @(posedge link_clk_in) disable iff (!arst_n_in) s_cs_sel |-> !scl_oe_out && !sda_oe_out;
  endproperty
  a_spi_no_two_wire: assert property (p_spi_no_two_wire) else $error("two-wire pins driven in spi");
  property p_stretch_short;
    @(posedge link_clk_in) disable iff (!arst_n_in) $rose(scl_oe_out) |-> ##[1:4] !scl_oe_out;
  endproperty
  a_stretch_short: assert property (p_stretch_short) else $error("clock stretch too long");
  property p_sda_moves_low;
    @(posedge link_clk_in) disable iff (!arst_n_in) $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_sda_moves_low: assert property (p_sda_moves_low) else $error("data changed with clock high");
  property p_ack_held;
    @(posedge link_clk_in) disable iff (!arst_n_in) $rose(scl_in) && sda_oe_out |-> sda_oe_out [*4];
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("data released in clock high");
  property p_disable_sticky;
    @(posedge link_clk_in) disable iff (!arst_n_in) two_wire_port_disable_out |=> two_wire_port_disable_out;
  endproperty
  a_disable_sticky: assert property (p_disable_sticky) else $error("disable bit cleared");
  property p_push_taken;
    @(posedge sys_clk_in) disable iff (!arst_n_in) s_push |=> !fifo_push_ready_out;
  endproperty
  a_push_taken: assert property (p_push_taken) else $error("push not taken");
  property p_ready_back;
    @(posedge sys_clk_in) disable iff (!arst_n_in) $fell(fifo_push_ready_out) |-> ##[1:40] fifo_push_ready_out;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("push ready stuck low");
endmodule

bind shssp_top shssp_chk #(.SENS_BYTES(SENS_BYTES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .link_clk_in(link_clk_in),
  .fifo_push_valid_in(fifo_push_valid_in), .fifo_push_ready_out(fifo_push_ready_out),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .sdo_oe_out(sdo_oe_out), .spi_chip_select_n_in(spi_chip_select_n_in),
  .two_wire_port_disable_out(two_wire_port_disable_out));

// *** tb/shssp_host_model.sv ***
module shssp_host_model (
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic sdo_in,
  output logic      scl_drv_out,
  output logic      sda_drv_out,
  output logic      cs_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 800; // Quarter bit: 312 kHz two-wire, 625 kHz spi
  initial begin
    scl_drv_out = 1'b1;
    sda_drv_out = 1'b1;
    cs_n_out = 1'b1;
  end
  // Master owns the clock; waits a bounded time while the slave holds it low
  task automatic bit_x(input logic b, output logic r);
    int n;
    n = 0;
    sda_drv_out = b;
    #Q scl_drv_out = 1'b1;
    while (scl_in !== 1'b1 && n < 100) begin
      #10;
      n++;
    end
    #Q r = sda_in;
    #Q scl_drv_out = 1'b0;
    #Q;
  endtask
  task automatic start_c();
    sda_drv_out = 1'b1;
    #Q scl_drv_out = 1'b1;
    #(2*Q) sda_drv_out = 1'b0;
    #Q scl_drv_out = 1'b0;
    #Q;
  endtask
  task automatic stop_c();
    sda_drv_out = 1'b0;
    #Q scl_drv_out = 1'b1;
    #(2*Q) sda_drv_out = 1'b1;
    #(2*Q);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
  task automatic spi_sel(input logic v);
    #Q cs_n_out = v;
    #Q sda_drv_out = 1'b1;
  endtask
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      scl_drv_out = 1'b0;
      sda_drv_out = tx[i];
      #Q scl_drv_out = 1'b1;
      rx[i] = sdo_in;
      #Q;
    end
  endtask
endmodule

// *** tb/test_sensor_host_serial_slave_port.sv ***
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module test_sensor_host_serial_slave_port;
  timeunit 1ns;
  timeprecision 1ps;
  import shssp_pkg::*;
  logic                    sys_clk = 1'b0;
  logic                    link_clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic [SENS_BYTES*8-1:0] sens = '0;
  logic                    sens_vld = 1'b0;
  logic [7:0]              push_d = 8'h00;
  logic                    push_vld = 1'b0;
  logic                    ad0_lvl = 1'b1;
  logic [7:0]              exp_q[$];
  logic [7:0]              obs_val = 8'h00;
  logic                    obs_tg = 1'b0;
  logic [31:0]             rng = 32'h38;
  int                      num_errors = 0;
  int                      total_checks = 0;
  wire logic scl_o, scl_oe, sda_o, sda_oe, sdo, sdo_oe, push_rdy, dis, m_scl, m_sda, m_cs_n;
  wire logic scl_pin = m_scl & (scl_oe ? scl_o : 1'b1);
  wire logic sda_pin = m_sda & (sda_oe ? sda_o : 1'b1);
  wire logic ad0_pin = sdo_oe ? sdo : ad0_lvl;
  shssp_top uut (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .link_clk_in(link_clk), .sensor_data_in(sens),
    .sensor_valid_in(sens_vld), .fifo_push_data_in(push_d), .fifo_push_valid_in(push_vld),
    .fifo_push_ready_out(push_rdy), .scl_in(scl_pin), .scl_out(scl_o), .scl_oe_out(scl_oe),
    .sda_in(sda_pin), .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_lsb_select_in(ad0_pin), .sdo_out(sdo),
    .sdo_oe_out(sdo_oe), .spi_chip_select_n_in(m_cs_n), .two_wire_port_disable_out(dis));
  shssp_host_model hm (.scl_in(scl_pin), .sda_in(sda_pin), .sdo_in(ad0_pin), .scl_drv_out(m_scl),
    .sda_drv_out(m_sda), .cs_n_out(m_cs_n));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end
  function automatic logic [7:0] rnd8();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction
  task automatic note(input logic [7:0] v);
    exp_q.push_back(v);
  endtask
  task automatic seen(input logic [7:0] v);
    obs_val = v;
    obs_tg = ~obs_tg;
    #1;
  endtask
  task automatic i2c_addr(input logic lsb, input logic rd, input logic exp_ack);
    logic a;
    note({7'h00, exp_ack});
    hm.start_c();
    hm.wr_byte({I2C_ADDR_HI, lsb, rd}, a);
    seen({7'h00, a});
  endtask
  task automatic wb(input logic [7:0] d);
    logic a;
    note(8'h00);
    hm.wr_byte(d, a);
    seen({7'h00, a});
  endtask
  task automatic i2c_wr(input logic [6:0] ra, input logic [7:0] d0, input logic [7:0] d1);
    i2c_addr(ad0_lvl, 1'b0, 1'b0);
    wb({1'b0, ra});
    wb(d0);
    wb(d1);
    hm.stop_c();
  endtask
  // Expected bytes are noted by the caller before the read
  task automatic i2c_rd(input logic [6:0] ra, input int n);
    logic [7:0] d;
    logic [7:0] held[$];
    // Data notes must queue behind the acknowledges of the addressing phase
    for (int i = 0; i < n; i++) held.push_front(exp_q.pop_back());
    i2c_addr(ad0_lvl, 1'b0, 1'b0);
    wb({1'b0, ra});
    i2c_addr(ad0_lvl, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) note(held.pop_front());
    for (int i = 0; i < n; i++) begin
      hm.rd_byte(i == n - 1, d);
      seen(d);
    end
    hm.stop_c();
  endtask
  task automatic spi_xfer(input logic [7:0] cmd, input logic [7:0] d0, input int n);
    logic [7:0] r;
    hm.spi_sel(1'b0);
    hm.spi_byte(cmd, r);
    for (int i = 0; i < n; i++) begin
      hm.spi_byte(d0, r);
      if (cmd[7]) seen(r);
    end
    hm.spi_sel(1'b1);
  endtask
  task automatic push(input logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (push_rdy !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    push_d = d;
    push_vld = 1'b1;
    @(negedge sys_clk);
    push_vld = 1'b0;
  endtask
  task automatic conclude();
    $display("Checks: %0d, errors: %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin : monitor
    logic [7:0] e;
    forever begin
      @(obs_tg);
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK(obs_val, e)
    end
  end
  initial begin : watchdog
    #3_000_000;
    num_errors++;
    $display("Error at %0t: run did not finish", $time);
    conclude();
  end
  initial begin : main
    logic [7:0] fb[3];
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge link_clk);
    note(8'h08);
    seen({3'h0, dis, push_rdy, scl_oe, sda_oe, sdo_oe});
    @(negedge sys_clk);
    for (int i = 0; i < SENS_BYTES; i++) sens[8*i +: 8] = rnd8();
    sens_vld = 1'b1;
    @(negedge sys_clk) sens_vld = 1'b0;
    repeat (40) @(negedge sys_clk);
    for (int l = 0; l < 2; l++) begin
      ad0_lvl = l[0];
      i2c_addr(~ad0_lvl, 1'b0, 1'b1);
      hm.stop_c();
      i2c_addr(ad0_lvl, 1'b0, 1'b0);
      hm.stop_c();
    end
    i2c_wr(REG_SENS_BASE, ~sens[7:0], ~sens[15:8]);
    for (int i = 0; i < 4; i++) note(sens[8*i +: 8]);
    i2c_rd(REG_SENS_BASE, 4);
    i2c_wr(REG_CFG, 8'h05, 8'h5a);
    note(8'h05);
    note(RD_UNMAPPED);
    i2c_rd(REG_CFG, 2);
    for (int i = 0; i < 3; i++) fb[i] = rnd8();
    for (int i = 0; i < 3; i++) push(fb[i]);
    repeat (40) @(negedge sys_clk);
    note(8'h00);
    note(8'h03);
    for (int i = 0; i < 3; i++) note(fb[i]);
    note(RD_EMPTY_VAL);
    i2c_rd(REG_FIFO_CNT_H, 6);
    note(8'h00);
    note(8'h00);
    i2c_rd(REG_FIFO_CNT_H, 2);
    spi_xfer({1'b0, REG_CFG}, 8'h10, 1);
    note(8'h10);
    spi_xfer({1'b1, REG_CFG}, 8'h00, 1);
    note(sens[7:0]);
    note(sens[15:8]);
    spi_xfer({1'b1, REG_SENS_BASE}, 8'h00, 2);
    note(8'h01);
    seen({7'h00, dis});
    for (int i = 0; i <= FIFO_DEPTH; i++) push(rnd8());
    repeat (40) @(negedge sys_clk);
    note(8'h02);
    note(8'h00);
    spi_xfer({1'b1, REG_FIFO_CNT_H}, 8'h00, 2);
    i2c_addr(ad0_lvl, 1'b0, 1'b1);
    hm.stop_c();
    #100;
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("Error at %0t: %0d results never seen", $time, exp_q.size());
    end
    conclude();
  end
endmodule
